// [core/hci_decode.sv]
// Command decoder: classifies a command word into group and sync/async kind
// Assumes a registered command word at its input
`default_nettype none
`include "hci_cfg.svh"
module hci_decode
	import hci_pkg::*;
(
	// Command
	input wire logic [15:0] cmd_i,
	// Classification
	output logic known_o,
	output logic async_o,
	output logic status_query_o
);
	logic [7:0] grp;
	logic [7:0] sub;
	assign grp = cmd_i[15:8];
	assign sub = cmd_i[7:0];
	always_comb begin
		known_o = 1'b0;
		async_o = 1'b0;
		status_query_o = 1'b0;
		case (grp)
			`HCI_GROUP_SYS: begin
				known_o = (sub <= 8'h02);
				async_o = (sub == 8'h00);
			end
			`HCI_GROUP_OVL: begin
				known_o = (sub <= `HCI_OVL_LAST);
				async_o = (sub == `HCI_OVL_LOAD_BUF) || (sub == `HCI_OVL_LOAD_STR);
				status_query_o = (sub == `HCI_OVL_LOAD_STAT);
			end
			`HCI_GROUP_STE: begin
				known_o = (sub >= `HCI_STE_DEFAULT) && (sub <= `HCI_STE_WRITE);
				async_o = (sub == `HCI_STE_LOAD);
				status_query_o = (sub == `HCI_STE_LOAD_STAT);
			end
			`HCI_GROUP_PIN: begin
				known_o = (sub <= `HCI_PIN_LAST);
			end
			default: begin
				known_o = 1'b0;
			end
		endcase
		if (!cmd_i[`HCI_DOORBELL_BIT]) begin
			known_o = 1'b0;
		end
	end
endmodule // hci_decode
`default_nettype wire

// [core/hci_device.sv]
// Device end: command register, doorbell, decoder dispatch, parameter pool
// Assumes host keeps pool and command writes apart from a pending command
`default_nettype none
`include "hci_cfg.svh"
module hci_device
	import hci_pkg::*;
(
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RESETN_I,
	// Link
	hci_if.device LINK,
	// Internal command source
	input wire logic INT_REQ_I,
	// Status
	output logic LOCKED_O,
	output logic PENDING_O,
	output logic [15:0] SYS_STATE_O
);
	logic [15:0] cmd_reg;
	logic [15:0] active_cmd;
	logic pending;
	logic [15:0] lock_cnt;
	logic locked;
	logic [15:0] int_cnt;
	logic int_busy;
	logic [15:0] eng_cnt [0:1];
	hci_load_t eng_load [0:1];
	hci_load_t ovl_load;
	hci_load_t ste_load;
	logic [15:0] pool [0:`HCI_POOL_WORDS-1];
	logic known;
	logic is_async;
	logic status_query;
	logic [7:0] next_status;
	logic [15:0] pool_rdata;
	logic host_cmd;
	logic [15:0] sys_state;
	logic [7:0] sub;

	assign host_cmd = LINK.cmd_wr && LINK.cmd_wdata[`HCI_DOORBELL_BIT];
	assign sub = active_cmd[7:0];

	hci_decode u_decode (
		.cmd_i(active_cmd),
		.known_o(known),
		.async_o(is_async),
		.status_query_o(status_query)
	);

	// ==========================================
	// Startup lock and internal activity
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			lock_cnt <= 16'h0000;
			locked <= 1'b1;
		end else if (locked) begin
			lock_cnt <= lock_cnt + 16'h0001;
			if (lock_cnt == `HCI_START_LOCK_CYCLES - 16'h0001) begin
				locked <= 1'b0;
			end
		end
	end

	// Internal commands run for a fixed time; a host command landing then is refused
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			int_cnt <= 16'h0000;
			int_busy <= 1'b0;
		end else if (int_busy) begin
			int_cnt <= int_cnt - 16'h0001;
			if (int_cnt == 16'h0001) begin
				int_busy <= 1'b0;
			end
		end else if (INT_REQ_I && !locked) begin
			int_busy <= 1'b1;
			int_cnt <= `HCI_INTERNAL_CYCLES;
		end
	end

	// ==========================================
	// Result selection
	always_comb begin
		next_status = `HCI_ST_SUCCESS;
		if (locked || int_busy) begin
			next_status = `HCI_ST_BUSY;
		end else if (!known) begin
			next_status = `HCI_ST_NOT_SUPPORTED;
		end else if (status_query) begin
			if (active_cmd[15:8] == `HCI_GROUP_OVL) begin
				next_status = (ovl_load == HCI_LOAD_RUN) ? `HCI_ST_BUSY
					: (ovl_load == HCI_LOAD_IDLE) ? `HCI_ST_NO_ENTITY
					: `HCI_ST_SUCCESS;
			end else begin
				next_status = (ste_load == HCI_LOAD_RUN) ? `HCI_ST_BUSY
					: (ste_load == HCI_LOAD_IDLE) ? `HCI_ST_NO_ENTITY
					: `HCI_ST_SUCCESS;
			end
		end else if (is_async) begin
			if (active_cmd[15:8] == `HCI_GROUP_OVL && ovl_load == HCI_LOAD_RUN) begin
				next_status = `HCI_ST_ALREADY_REQ;
			end else if (active_cmd[15:8] == `HCI_GROUP_STE && ste_load == HCI_LOAD_RUN) begin
				next_status = `HCI_ST_ALREADY_REQ;
			end
		end
	end

	// ==========================================
	// Command register and doorbell
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			cmd_reg <= 16'h0000;
			active_cmd <= 16'h0000;
			pending <= 1'b0;
		end else if (host_cmd && !pending) begin
			cmd_reg <= LINK.cmd_wdata;
			active_cmd <= LINK.cmd_wdata;
			pending <= 1'b1;
		end else if (pending) begin
			cmd_reg <= {8'h00, next_status};
			pending <= 1'b0;
		end
	end

	// ==========================================
	// Asynchronous load engines: entry 0 overlay, entry 1 transform engine
	for (genvar e = 0; e < 2; e++) begin : g_eng
		localparam logic [7:0] ENG_GRP = (e == 0) ? `HCI_GROUP_OVL : `HCI_GROUP_STE;
		always_ff @(posedge CLK_I or negedge RESETN_I) begin
			if (!RESETN_I) begin
				eng_load[e] <= HCI_LOAD_IDLE;
				eng_cnt[e] <= 16'h0000;
			end else begin
				case (eng_load[e])
					HCI_LOAD_RUN: begin
						eng_cnt[e] <= eng_cnt[e] - 16'h0001;
						if (eng_cnt[e] == 16'h0001) begin
							eng_load[e] <= HCI_LOAD_DONE;
						end
					end
					default: begin
						// A finished load may restart; a running one answers already-requested
						if (pending && next_status == `HCI_ST_SUCCESS && is_async
							&& active_cmd[15:8] == ENG_GRP) begin
							eng_load[e] <= HCI_LOAD_RUN;
							eng_cnt[e] <= `HCI_ASYNC_CYCLES;
						end
					end
				endcase
			end
		end
	end
	assign ovl_load = eng_load[0];
	assign ste_load = eng_load[1];

	// ==========================================
	// System state
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			sys_state <= 16'h0000;
		end else if (pending && next_status == `HCI_ST_SUCCESS
			&& active_cmd == `HCI_CMD_SET_STATE) begin
			sys_state <= pool[0];
		end
	end

	// ==========================================
	// Parameter pool: host writes only while idle, device answers into word 0
	always_ff @(posedge CLK_I) begin
		if (LINK.pool_wr && !pending) begin
			pool[LINK.pool_addr] <= LINK.pool_wdata;
		end else if (pending && next_status == `HCI_ST_SUCCESS) begin
			if (active_cmd == `HCI_CMD_GET_STATE) begin
				pool[0] <= sys_state;
			end else if (status_query) begin
				pool[0] <= {8'h00, sub};
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			pool_rdata <= 16'h0000;
		end else begin
			pool_rdata <= pool[LINK.pool_addr];
		end
	end

	assign LINK.cmd_rdata = cmd_reg;
	assign LINK.pool_rdata = pool_rdata;
	assign LOCKED_O = locked;
	assign PENDING_O = pending;
	assign SYS_STATE_O = sys_state;
endmodule // hci_device
`default_nettype wire

// [core/hci_host.sv]
// Host end: start-up wait, parameter load, command issue, busy retry, result return
// Assumes device answers within a few cycles of a command write
`default_nettype none
`include "hci_cfg.svh"
module hci_host
	import hci_pkg::*;
(
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RESETN_I,
	// Link
	hci_if.host LINK,
	// User request
	input wire logic REQ_I,
	input wire logic [15:0] REQ_CMD_I,
	input wire logic [15:0] REQ_PARAM_I,
	// User answer
	output logic READY_O,
	output logic DONE_O,
	output logic [7:0] STATUS_O,
	output logic [15:0] RESP_O
);
	typedef enum logic [3:0] {H_BOOT, H_BOOT_QUERY, H_BOOT_WAIT, H_IDLE, H_PARAM, H_CMD,
		H_WAIT, H_GAP, H_READ, H_DONE} hci_hstate_t;
	hci_hstate_t state;
	logic [7:0] retries;
	logic [7:0] gap;
	logic boot;
	logic [15:0] cmd;
	logic [15:0] param;
	logic [7:0] status;
	logic [15:0] resp;
	logic done;

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state <= H_BOOT;
			retries <= `HCI_POLL_RETRIES;
			gap <= 8'h00;
			boot <= 1'b1;
			cmd <= 16'h0000;
			param <= 16'h0000;
			status <= 8'h00;
			resp <= 16'h0000;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				H_BOOT: begin
					if (!LINK.cmd_rdata[`HCI_DOORBELL_BIT]) begin
						state <= H_BOOT_QUERY;
						retries <= `HCI_POLL_RETRIES;
					end else if (retries == 8'h00) begin
						status <= `HCI_ST_IO_FAILURE;
						state <= H_DONE;
					end else begin
						retries <= retries - 8'h01;
					end
				end
				H_BOOT_QUERY: begin
					cmd <= `HCI_CMD_GET_STATE;
					state <= H_CMD;
				end
				H_IDLE: begin
					if (REQ_I) begin
						cmd <= REQ_CMD_I;
						param <= REQ_PARAM_I;
						retries <= `HCI_POLL_RETRIES;
						state <= H_PARAM;
					end
				end
				H_PARAM: begin
					state <= H_CMD;
				end
				H_CMD: begin
					state <= H_WAIT;
				end
				H_WAIT: begin
					if (!LINK.cmd_rdata[`HCI_DOORBELL_BIT]) begin
						if (LINK.cmd_rdata[7:0] == `HCI_ST_BUSY) begin
							if (retries == 8'h00) begin
								status <= `HCI_ST_TRY_AGAIN;
								state <= H_DONE;
							end else begin
								retries <= retries - 8'h01;
								gap <= `HCI_RETRY_GAP;
								state <= H_GAP;
							end
						end else begin
							status <= LINK.cmd_rdata[7:0];
							state <= H_READ;
						end
					end
				end
				H_GAP: begin
					gap <= gap - 8'h01;
					if (gap == 8'h01) begin
						state <= H_CMD;
					end
				end
				H_READ: begin
					state <= H_BOOT_WAIT;
				end
				H_BOOT_WAIT: begin
					resp <= LINK.pool_rdata;
					state <= H_DONE;
				end
				H_DONE: begin
					boot <= 1'b0;
					done <= !boot;
					state <= H_IDLE;
				end
				default: begin
					state <= H_IDLE;
				end
			endcase
		end
	end

	// Writes are combinational strobes keyed on state; data comes from registers
	assign LINK.pool_wr = (state == H_PARAM);
	assign LINK.pool_addr = 3'h0;
	assign LINK.pool_wdata = param;
	assign LINK.cmd_wr = (state == H_CMD);
	assign LINK.cmd_wdata = cmd;
	assign READY_O = (state == H_IDLE);
	assign DONE_O = done;
	assign STATUS_O = status;
	assign RESP_O = resp;
endmodule // hci_host
`default_nettype wire

// [shared/hci_cfg.svh]
// Host command interpreter constants: command values, result codes, pool and timing figures
// Assumes inclusion by bare name from package and modules
`ifndef HCI_CFG_SVH
`define HCI_CFG_SVH
// ==========================================
// Command word layout
`define HCI_DOORBELL_BIT 15
`define HCI_GROUP_SYS 8'h81
`define HCI_GROUP_OVL 8'h82
`define HCI_GROUP_STE 8'h83
`define HCI_GROUP_PIN 8'h84
`define HCI_CMD_SET_STATE 16'h8100
`define HCI_CMD_GET_STATE 16'h8101
`define HCI_CMD_PWR_CFG 16'h8102
`define HCI_OVL_LAST 8'h0e
`define HCI_OVL_LOAD_BUF 8'h06
`define HCI_OVL_LOAD_STAT 8'h07
`define HCI_OVL_LOAD_STR 8'h0e
`define HCI_STE_DEFAULT 8'h10
`define HCI_STE_LOAD 8'h11
`define HCI_STE_LOAD_STAT 8'h12
`define HCI_STE_WRITE 8'h13
`define HCI_PIN_LAST 8'h05
// ==========================================
// Result codes
`define HCI_ST_SUCCESS 8'h00
`define HCI_ST_NO_ENTITY 8'h01
`define HCI_ST_INTERRUPTED 8'h02
`define HCI_ST_IO_FAILURE 8'h03
`define HCI_ST_TOO_BIG 8'h04
`define HCI_ST_BAD_HANDLE 8'h05
`define HCI_ST_TRY_AGAIN 8'h06
`define HCI_ST_NO_MEMORY 8'h07
`define HCI_ST_DENIED 8'h08
`define HCI_ST_BUSY 8'h09
`define HCI_ST_EXISTS 8'h0a
`define HCI_ST_NO_DEVICE 8'h0b
`define HCI_ST_INVALID_ARG 8'h0c
`define HCI_ST_NO_SPACE 8'h0d
`define HCI_ST_OUT_OF_RANGE 8'h0e
`define HCI_ST_NOT_SUPPORTED 8'h0f
`define HCI_ST_ALREADY_REQ 8'h10
// ==========================================
// Pool and timing
`define HCI_POOL_WORDS 8
`define HCI_START_LOCK_CYCLES 16'h0040
`define HCI_ASYNC_CYCLES 16'h0020
`define HCI_INTERNAL_CYCLES 16'h0010
`define HCI_POLL_RETRIES 8'h0a
`define HCI_RETRY_GAP 8'h08
`endif

// [shared/hci_if.sv]
// Link between host and device: command register and parameter pool access
// Assumes one clock shared by both ends
`default_nettype none
interface hci_if (input wire logic clk);
	import hci_pkg::*;
	logic cmd_wr;
	hci_word_t cmd_wdata;
	hci_word_t cmd_rdata;
	logic pool_wr;
	hci_addr_t pool_addr;
	hci_word_t pool_wdata;
	hci_word_t pool_rdata;
	modport device (input cmd_wr, cmd_wdata, pool_wr, pool_addr, pool_wdata,
		output cmd_rdata, pool_rdata);
	modport host (output cmd_wr, cmd_wdata, pool_wr, pool_addr, pool_wdata,
		input cmd_rdata, pool_rdata);
endinterface
`default_nettype wire

// [shared/hci_pkg.sv]
// Types shared by both ends of the host command interpreter
// Assumes hci_cfg.svh on the include path
`default_nettype none
`include "hci_cfg.svh"
package hci_pkg;
	typedef logic [15:0] hci_word_t;
	typedef logic [2:0] hci_addr_t;
	typedef enum logic [1:0] {HCI_LOAD_IDLE, HCI_LOAD_RUN, HCI_LOAD_DONE} hci_load_t;
endpackage
`default_nettype wire

// [tb/hci_link_properties.sv]
// Concurrent checks on the link between host end and device end
// Assumes one clock and an active-low reset supplied by the bench
`default_nettype none
module hci_link_properties
	import hci_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link
	input wire logic cmd_wr,
	input wire hci_word_t cmd_wdata,
	input wire hci_word_t cmd_rdata,
	input wire logic pool_wr,
	input wire hci_addr_t pool_addr,
	input wire hci_word_t pool_wdata,
	input wire hci_word_t pool_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Helpers
	logic [7:0] up_cnt;
	logic known;
	logic ring;
	// Margin below the lock length, so a late write still lands inside it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) up_cnt <= 8'h00;
		else if (up_cnt != 8'hff) up_cnt <= up_cnt + 8'h01;
	end
	always_comb begin
		case (cmd_wdata[15:8])
			8'h81: known = cmd_wdata[7:0] <= 8'h02;
			8'h82: known = cmd_wdata[7:0] <= 8'h0e;
			8'h83: known = cmd_wdata[7:0] >= 8'h10 && cmd_wdata[7:0] <= 8'h13;
			8'h84: known = cmd_wdata[7:0] <= 8'h05;
			default: known = 1'b0;
		endcase
	end
	assign ring = cmd_wr && cmd_wdata[15];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========================================
	// Assertions
	a_result_high_clear: assert property (ring |-> ##2 cmd_rdata[15:8] == 8'h00)
		else $error("result upper byte not clear");
	a_result_code_range: assert property (ring |-> ##2 cmd_rdata[7:0] <= 8'h10)
		else $error("result code out of table");
	a_unknown_rejected: assert property (ring && !known |-> ##2
		(cmd_rdata == 16'h000f || cmd_rdata == 16'h0009))
		else $error("unknown command not refused");
	a_known_accepted: assert property (ring && known |-> ##2 cmd_rdata != 16'h000f)
		else $error("known command refused");
	a_lock_busy: assert property (ring && up_cnt < 8'h3c |-> ##2 cmd_rdata == 16'h0009)
		else $error("command taken during start-up lock");
	a_result_stands: assert property (!cmd_wr [*3] |=> $stable(cmd_rdata))
		else $error("result changed without command");
	a_cmd_spacing: assert property (ring |=> !cmd_wr [*2])
		else $error("command issued before doorbell clear");
	a_pool_quiet: assert property (cmd_wr |=> !pool_wr [*2])
		else $error("pool written while pending");
	a_param_first: assert property (cmd_wr && cmd_wdata == 16'h8100 |-> $past(pool_wr))
		else $error("parameter not written before command");
	// ==========================================
	// Covers
	c_already: cover property (ring ##2 cmd_rdata == 16'h0010);
	c_unsupported: cover property (ring ##2 cmd_rdata == 16'h000f);
	c_busy: cover property (ring ##2 cmd_rdata == 16'h0009);
endmodule // hci_link_properties
`default_nettype wire

// [tb/tb.sv]
// Bench: host end and device end joined by the link, driven from the host user side and the device internal request input
// Assumes the shared package, interface and both ends compiled before it
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Signals
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic req = 1'b0;
	logic [15:0] req_cmd = 16'h0000;
	logic [15:0] req_param = 16'h0000;
	logic int_req = 1'b0;
	logic ready, done, locked, pending;
	logic [7:0] status, st;
	logic [15:0] resp, sys_state, rs;
	logic [15:0] prev_rd = 16'h0000;
	int n_fail = 0;
	int cmp_count = 0;
	int busy_cnt = 0;
	int pend_cnt = 0;
	int b0;
	logic [15:0] known_tab [14] = '{16'h8102, 16'h8200, 16'h8201, 16'h8203, 16'h8204,
		16'h8205, 16'h8208, 16'h820a, 16'h820d, 16'h8310, 16'h8313, 16'h8400, 16'h8402,
		16'h8405};
	logic [15:0] unk_tab [7] = '{16'h8103, 16'h820f, 16'h830f, 16'h8314, 16'h8406,
		16'h8500, 16'h8000};
	logic [15:0] ld_tab [2] = '{16'h8311, 16'h8206};
	logic [15:0] ls_tab [2] = '{16'h8312, 16'h8207};
	hci_if lk (.clk(clk));
	hci_host i_hci_host (.CLK_I(clk), .RESETN_I(rst_n), .LINK(lk), .REQ_I(req),
		.REQ_CMD_I(req_cmd), .REQ_PARAM_I(req_param), .READY_O(ready), .DONE_O(done),
		.STATUS_O(status), .RESP_O(resp));
	hci_device i_hci_device (.CLK_I(clk), .RESETN_I(rst_n), .LINK(lk), .INT_REQ_I(int_req),
		.LOCKED_O(locked), .PENDING_O(pending), .SYS_STATE_O(sys_state));
	hci_link_properties i_hci_link_properties (.clk(clk), .rst_n(rst_n), .cmd_wr(lk.cmd_wr),
		.cmd_wdata(lk.cmd_wdata), .cmd_rdata(lk.cmd_rdata), .pool_wr(lk.pool_wr),
		.pool_addr(lk.pool_addr), .pool_wdata(lk.pool_wdata), .pool_rdata(lk.pool_rdata));
	initial begin
		forever #10 clk = ~clk;
	end
	// Host retries may hide a busy answer, so busy is counted on the wire; doorbell pulses too
	always @(posedge clk) begin
		if (lk.cmd_rdata === 16'h0009 && prev_rd !== 16'h0009) busy_cnt++;
		if (pending === 1'b1) pend_cnt++;
		prev_rd = lk.cmd_rdata;
	end
	// ==========================================
	// Tasks
	task automatic final_report();
		$display("Compares %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic flag(input logic f);
		chk({15'h0000, f}, 16'h0001);
	endtask
	task automatic wait_for(input bit on_done);
		int n;
		n = 0;
		while ((on_done ? done : ready) !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 400) begin
				n_fail++;
				$display("ERROR %0t: wait ran out", $time);
				final_report();
			end
		end
	endtask
	task automatic do_cmd(input logic [15:0] c, input logic [15:0] p);
		@(negedge clk);
		wait_for(1'b0);
		@(posedge clk);
		req <= 1'b1;
		req_cmd <= c;
		req_param <= p;
		@(posedge clk);
		req <= 1'b0;
		@(negedge clk);
		wait_for(1'b1);
		st = status;
		rs = resp;
	endtask
	task automatic run(input logic [15:0] c, input logic [15:0] p, input logic [7:0] e);
		int p0;
		p0 = pend_cnt;
		do_cmd(c, p);
		chk({8'h00, st}, {8'h00, e});
		chk(lk.cmd_rdata, {8'h00, e});
		chk(16'(pend_cnt - p0), 16'h0001);
	endtask
	// ==========================================
	// Sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		flag(locked);
		wait_for(1'b0);
		flag(!locked);
		flag(busy_cnt != 0);
		$display("Test boot done");
		run(16'h8100, 16'h5a3c, 8'h00);
		chk(sys_state, 16'h5a3c);
		run(16'h8101, 16'h0000, 8'h00);
		chk(rs, 16'h5a3c);
		$display("Test state done");
		foreach (known_tab[i]) run(known_tab[i], 16'h0000, 8'h00);
		foreach (unk_tab[i]) run(unk_tab[i], 16'h0000, 8'h0f);
		$display("Test decode done");
		for (int g = 0; g < 2; g++) begin
			run(ls_tab[g], 16'h0000, 8'h01);
			run(ld_tab[g], 16'h0000, 8'h00);
			run(ld_tab[g], 16'h0000, 8'h10);
			b0 = busy_cnt;
			do_cmd(ls_tab[g], 16'h0000);
			flag(busy_cnt != b0);
			flag(st === 8'h00 || st === 8'h09);
			repeat (40) @(posedge clk);
			run(ls_tab[g], 16'h0000, 8'h00);
		end
		run(16'h820e, 16'h0000, 8'h00);
		run(16'h820e, 16'h0000, 8'h10);
		$display("Test async done");
		@(posedge clk);
		int_req <= 1'b1;
		@(posedge clk);
		int_req <= 1'b0;
		b0 = busy_cnt;
		do_cmd(16'h8102, 16'h0000);
		flag(busy_cnt != b0);
		flag(st === 8'h00 || st === 8'h09);
		$display("Test collide done");
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		b0 = busy_cnt;
		@(negedge clk);
		wait_for(1'b0);
		flag(busy_cnt != b0);
		run(16'h8101, 16'h0000, 8'h00);
		$display("Test reset done");
		final_report();
	end
endmodule // tb
`default_nettype wire
